// ---- design/dwmd_pkg.sv ----
// Package: frame layout, command codes and register map of the write/mode-entry decoder
package dwmd_pkg;
    // Command nibble codes
    localparam logic [3:0] CMD_REG_WRITE   = 4'h8;
    localparam logic [3:0] CMD_ENTER_PER   = 4'hB;
    localparam logic [3:0] GLOBAL_ADDR     = 4'h0;
    // Register byte addresses
    localparam logic [7:0] NODE_ADDR_REG   = 8'h11;
    localparam logic [7:0] NEXT_ADDR_REG   = 8'h12;
    // Frame field positions (32-bit frame, CRC in the low byte)
    localparam int         ADDR_MSB        = 31;
    localparam int         ADDR_LSB        = 28;
    localparam int         CMD_MSB         = 27;
    localparam int         CMD_LSB         = 24;
    // Node address reset value and periodic enable bit value
    localparam logic [7:0] NODE_ADDR_RST   = 8'h00;
    localparam logic [7:0] PER_ENABLE_BIT  = 8'h01;
    // Periodic-mode response marker bit
    localparam logic [7:0] PER_RESP_LOW    = 8'h80;
    localparam logic [4:0] PER_RESP_HIGH   = 5'h00;
    // CRC-8 polynomial x^8+x^4+x^3+x^2+1 and seed
    localparam logic [7:0] CRC_POLY        = 8'h1D;
    localparam logic [7:0] CRC_SEED        = 8'hFF;
endpackage

// ---- design/dwmd_crc8.sv ----
// CRC-8 over a 24-bit frame body, combinational
`timescale 1ns/1ps
module dwmd_crc8 (
    input  wire logic [23:0] body_i,
    output logic      [7:0]  crc_o
);
    // Bitwise MSB-first shift
    always_comb begin
        logic [7:0] c;
        c = dwmd_pkg::CRC_SEED;
        for (int i = 23; i >= 0; i--) begin
            if (c[7] ^ body_i[i]) begin
                c = {c[6:0], 1'b0} ^ dwmd_pkg::CRC_POLY;
            end else begin
                c = {c[6:0], 1'b0};
            end
        end
        crc_o = c;
    end
endmodule

// ---- design/dwmd_decoder.sv ----
// Command decoder: addressed/global register write and enter-periodic-mode
`timescale 1ns/1ps
module dwmd_decoder (
    input  wire logic        clk_sys_i,
    input  wire logic        rst_n_i,
    input  wire logic        frame_valid_i,
    input  wire logic [31:0] frame_data_i,
    input  wire logic [7:0]  reg_rdata_lo_i,
    input  wire logic [7:0]  reg_rdata_hi_i,
    input  wire logic        reg_writable_i,
    input  wire logic [2:0]  chip_time_setting_i,
    output logic             reg_wr_o,
    output logic      [7:0]  register_byte_address_o,
    output logic      [7:0]  reg_wdata_o,
    output logic      [7:0]  reg_rd_addr_o,
    output logic      [7:0]  node_address_register_o,
    output logic             periodic_mode_enable_o,
    output logic             periodic_collection_mode_o,
    output logic             resp_valid_o,
    output logic      [31:0] resp_frame_o
);
    // Overview of the decoder
    //
    // Frames arrive whole, one per strobe
    // Bit coding and frame timing live upstream
    // Only three command kinds are acted on here
    // Everything else passes by without effect
    //
    // Frame layout seen on the data input
    //   Top nibble: target node address
    //   Next nibble: command code
    //   Middle sixteen bits: command data
    //   Low byte: check byte over the rest
    //
    // Addressed register write
    //   Needs the stored node address in the frame
    //   Strobes the register file one cycle later
    //   Answers two cycles after the strobe
    //   Answer low byte: target after the write, zero if unwritable
    //   Answer high byte: the next register up, zero if unwritable
    //
    // Global address assignment
    //   Frame address zero, target the address register
    //   Only while the stored node address is zero
    //   Upper data nibble is forced to zero
    //   Answer carries the new node address
    //
    // Periodic entry
    //   Data field must be all zero
    //   Own nonzero address: mode bits set, answer next cycle
    //   Zero address: mode bits set, no answer
    //   Any other address: nothing at all
    //
    // Sequencing
    //   Writes take three cycles from frame to answer
    //   Frames inside that window are dropped
    //   The master is expected to space its frames
    //   Periodic entry is a one-cycle affair
    //
    // Register file handshake
    //   Write strobe is combinational from state
    //   Read data is combinational from read address
    //   Read address stays at the target all along
    //   So high byte is always the register above it
    //
    // Limitations
    //   Node address register lives here, not outside
    //   So address register writes never strobe out
    //   Writability is asked of the outside file
    //   No way out of periodic mode but reset
    //   A fresh node at zero also takes zero writes
    //   Check byte errors are dropped silently
    //
    // Trade-offs
    //   Answer frame is registered for clean timing
    //   Costs one cycle but avoids glitchy outputs
    //   Check byte logic is shared by one module
    //   Used once for receive, once for send

    typedef enum logic [2:0] {
        DWMD_IDLE  = 3'b001,
        DWMD_WRITE = 3'b010,
        DWMD_RESP  = 3'b100
    } dwmd_state_t;

    dwmd_state_t state_r;
    logic [3:0]  frame_node_address;
    logic [3:0]  cmd;
    logic [7:0]  ra;
    logic [7:0]  rd;
    logic [7:0]  crc_calc;
    logic        crc_ok;
    logic        own_hit;
    logic        glb_hit;
    logic        wr_addr_ok;
    logic        wr_glb_ok;
    logic        per_ok;
    logic        glb_cmd_r;
    logic [7:0]  ra_r;
    logic [7:0]  rd_r;
    logic        wr_ok_r;
    logic [3:0]  resp_addr;
    logic [23:0] resp_body;
    logic [7:0]  resp_crc;

    // Frame field split
    // Positions fixed, so plain part-selects suffice
    assign frame_node_address = frame_data_i[dwmd_pkg::ADDR_MSB:dwmd_pkg::ADDR_LSB];
    assign cmd                = frame_data_i[dwmd_pkg::CMD_MSB:dwmd_pkg::CMD_LSB];
    assign ra                 = frame_data_i[23:16];
    assign rd                 = frame_data_i[15:8];

    // Receive check byte over address, command, data
    // Pure logic, settles within the frame cycle
    dwmd_crc8 u_rx_crc (
        .body_i (frame_data_i[31:8]),
        .crc_o  (crc_calc)
    );

    // Frame acceptance; CRC is in the low byte
    assign crc_ok  = frame_valid_i && (crc_calc == frame_data_i[7:0]);
    assign own_hit = (frame_node_address == node_address_register_o[3:0]);
    assign glb_hit = (frame_node_address == dwmd_pkg::GLOBAL_ADDR);
    // Own address zero counts as addressed too, so a fresh node answers at 0
    assign wr_addr_ok = crc_ok && (cmd == dwmd_pkg::CMD_REG_WRITE) && own_hit;
    assign wr_glb_ok  = crc_ok && (cmd == dwmd_pkg::CMD_REG_WRITE) && glb_hit
                        && (ra == dwmd_pkg::NODE_ADDR_REG)
                        && (node_address_register_o[3:0] == dwmd_pkg::GLOBAL_ADDR);
    // Data must be all zero for a legal entry frame
    assign per_ok = crc_ok && (cmd == dwmd_pkg::CMD_ENTER_PER) && (frame_data_i[23:8] == 16'h0000)
                    && (own_hit || glb_hit);

    // Sequencer: write strobe then answer step one cycle later, once data has settled
    // Idle waits for a write; two fixed steps follow
    // Periodic entry never leaves idle
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            state_r <= DWMD_IDLE;
        end else begin
            case (state_r)
                DWMD_IDLE: begin
                    if (wr_addr_ok || wr_glb_ok) begin
                        state_r <= DWMD_WRITE;
                    end
                end
                DWMD_WRITE: begin
                    state_r <= DWMD_RESP;
                end
                DWMD_RESP: begin
                    state_r <= DWMD_IDLE;
                end
                default: begin
                    state_r <= DWMD_IDLE;
                end
            endcase
        end
    end

    // Latch the write request
    // Held until the next accepted write
    // Keeps strobe address and data steady for the file
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            ra_r      <= 8'h00;
            rd_r      <= 8'h00;
            glb_cmd_r <= 1'b0;
        end else if (state_r == DWMD_IDLE && (wr_addr_ok || wr_glb_ok)) begin
            ra_r      <= ra;
            rd_r      <= wr_glb_ok ? {4'h0, rd[3:0]} : rd;
            glb_cmd_r <= wr_glb_ok;
        end
    end

    // Writability snapshot taken at strobe time
    // Address register is always writable here
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            wr_ok_r <= 1'b0;
        end else if (state_r == DWMD_WRITE) begin
            wr_ok_r <= reg_writable_i || glb_cmd_r;
        end
    end

    // Register write strobe to the device register file
    assign reg_wr_o                = (state_r == DWMD_WRITE) && !glb_cmd_r && (ra_r != dwmd_pkg::NODE_ADDR_REG);
    assign register_byte_address_o = ra_r;
    assign reg_wdata_o             = rd_r;
    // Read address is the target; high byte comes from the place above it
    // For the address register that place is 0x12
    assign reg_rd_addr_o = ra_r;

    // Node address register held here, written addressed or globally
    // Updated in the strobe cycle, so the answer sees the new value
    // Global data was already cut to four bits
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            node_address_register_o <= dwmd_pkg::NODE_ADDR_RST;
        end else if (state_r == DWMD_WRITE && ra_r == dwmd_pkg::NODE_ADDR_REG) begin
            node_address_register_o <= rd_r;
        end
    end

    // Mode entry; there is no exit here, leaving is a reset
    // Frames during a write are not looked at
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            periodic_mode_enable_o     <= 1'b0;
            periodic_collection_mode_o <= 1'b0;
        end else if (per_ok && state_r == DWMD_IDLE) begin
            periodic_mode_enable_o     <= dwmd_pkg::PER_ENABLE_BIT[0];
            periodic_collection_mode_o <= 1'b1;
        end
    end

    // Answer assembly; address field uses the (possibly new) node address
    // Write answers built in the answer step
    // Periodic answers built straight from idle
    // Frame held until the next answer
    assign resp_addr = node_address_register_o[3:0];
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            resp_valid_o <= 1'b0;
            resp_frame_o <= 32'h0000_0000;
        end else begin
            resp_valid_o <= 1'b0;
            if (state_r == DWMD_RESP) begin
                resp_valid_o <= 1'b1;
                if (ra_r == dwmd_pkg::NODE_ADDR_REG) begin
                    resp_frame_o <= {resp_addr, dwmd_pkg::CMD_REG_WRITE, reg_rdata_hi_i,
                                     node_address_register_o, resp_crc};
                end else if (wr_ok_r) begin
                    resp_frame_o <= {resp_addr, dwmd_pkg::CMD_REG_WRITE, reg_rdata_hi_i,
                                     reg_rdata_lo_i, resp_crc};
                end else begin
                    resp_frame_o <= {resp_addr, dwmd_pkg::CMD_REG_WRITE, 16'h0000, resp_crc};
                end
            end else if (per_ok && own_hit && !glb_hit && state_r == DWMD_IDLE) begin
                // Global entry never answers, even for a node still at zero
                resp_valid_o <= 1'b1;
                resp_frame_o <= {resp_addr, dwmd_pkg::CMD_ENTER_PER, dwmd_pkg::PER_RESP_HIGH,
                                 chip_time_setting_i, dwmd_pkg::PER_RESP_LOW, resp_crc};
            end
        end
    end

    // Body for the outgoing CRC, chosen the same way as the frame
    // Must track the frame mux exactly, else the check byte lies
    // Outside the answer step the periodic body is kept ready
    always_comb begin
        if (state_r == DWMD_RESP) begin
            if (ra_r == dwmd_pkg::NODE_ADDR_REG) begin
                resp_body = {resp_addr, dwmd_pkg::CMD_REG_WRITE, reg_rdata_hi_i, node_address_register_o};
            end else if (wr_ok_r) begin
                resp_body = {resp_addr, dwmd_pkg::CMD_REG_WRITE, reg_rdata_hi_i, reg_rdata_lo_i};
            end else begin
                resp_body = {resp_addr, dwmd_pkg::CMD_REG_WRITE, 16'h0000};
            end
        end else begin
            resp_body = {resp_addr, dwmd_pkg::CMD_ENTER_PER, dwmd_pkg::PER_RESP_HIGH,
                         chip_time_setting_i, dwmd_pkg::PER_RESP_LOW};
        end
    end


    // Send check byte over the chosen answer body
    // Same polynomial and seed as on receive
    dwmd_crc8 u_tx_crc (
        .body_i (resp_body),
        .crc_o  (resp_crc)
    );
endmodule

// ---- verification/dwmd_master.sv ----
// Bus master model: frames commands with a trailing CRC
`timescale 1ns/1ps
module dwmd_master (
    input  wire logic        clk_sys_i,
    output logic             frame_valid_o,
    output logic      [31:0] frame_data_o
);
    // CRC-8, MSB first over address, command and data
    function automatic logic [7:0] crc8(input logic [23:0] b);
        logic [7:0] c;
        c = dwmd_pkg::CRC_SEED;
        for (int i = 23; i >= 0; i--) begin
            c = {c[6:0], 1'h0} ^ ((c[7] ^ b[i]) ? dwmd_pkg::CRC_POLY : 8'h00);
        end
        return c;
    endfunction
    initial begin
        frame_valid_o = 1'h0;
        frame_data_o  = 32'h0000_0000;
    end
    // One-cycle strobe; idle bus is inverted so stale data never looks valid
    task automatic send(input logic [3:0] a, input logic [3:0] c, input logic [15:0] d, input logic bad);
        @(posedge clk_sys_i);
        #1;
        frame_data_o  = {a, c, d, crc8({a, c, d}) ^ {7'h00, bad}};
        frame_valid_o = 1'h1;
        @(posedge clk_sys_i);
        #1;
        frame_valid_o = 1'h0;
        frame_data_o  = ~frame_data_o;
    endtask
endmodule

// ---- verification/dwmd_decoder_chk.sv ----
// Port checker for the command decoder
`timescale 1ns/1ps
module dwmd_chk (
    input wire logic        clk_sys_i,
    input wire logic        rst_n_i,
    input wire logic        frame_valid_i,
    input wire logic [31:0] frame_data_i,
    input wire logic [7:0]  reg_rdata_lo_i,
    input wire logic [7:0]  reg_rdata_hi_i,
    input wire logic        reg_writable_i,
    input wire logic [2:0]  chip_time_setting_i,
    input wire logic        reg_wr_o,
    input wire logic [7:0]  register_byte_address_o,
    input wire logic [7:0]  reg_wdata_o,
    input wire logic [7:0]  reg_rd_addr_o,
    input wire logic [7:0]  node_address_register_o,
    input wire logic        periodic_mode_enable_o,
    input wire logic        periodic_collection_mode_o,
    input wire logic        resp_valid_o,
    input wire logic [31:0] resp_frame_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    wire [3:0] nd = node_address_register_o[3:0];
    wire [3:0] fa = frame_data_i[31:28];
    // Mode entry frame seen, and write strobe followed by its answer
    sequence s_per;
        frame_valid_i && frame_data_i[27:24] == dwmd_pkg::CMD_ENTER_PER;
    endsequence
    sequence s_wr_done;
        reg_wr_o ##2 resp_valid_o;
    endsequence
    chk_wr_match: assert property (reg_wr_o |-> $past(frame_data_i[31:24]) == {nd, 4'h8})
        else $error("write strobe without matching frame");
    chk_wr_fields: assert property (reg_wr_o |-> {register_byte_address_o, reg_wdata_o} == $past(frame_data_i[23:8]))
        else $error("write address or data wrong");
    chk_wr_answer: assert property (reg_wr_o |-> ##2 resp_valid_o && resp_frame_o[31:24] == {nd, 4'h8})
        else $error("write answer missing");
    chk_wr_data: assert property (s_wr_done |-> resp_frame_o[23:8] ==
        ($past(reg_writable_i, 2) ? {$past(reg_rdata_hi_i), $past(reg_rdata_lo_i)} : 16'h0000))
        else $error("write answer data wrong");
    chk_node_assign: assert property ($changed(nd) && $past(nd) == 4'h0 |=>
        resp_valid_o && resp_frame_o[31:28] == nd && resp_frame_o[15:8] == node_address_register_o)
        else $error("assignment answer wrong");
    chk_per_silent: assert property (s_per ##0 fa != nd |=> !resp_valid_o)
        else $error("answer to foreign mode entry");
    chk_per_ignore: assert property (s_per ##0 (fa != nd && fa != 4'h0 && !periodic_mode_enable_o)
        |=> !periodic_mode_enable_o [*2]) else $error("mode entered for other node");
    chk_per_answer: assert property (resp_valid_o && resp_frame_o[27:24] == 4'hB |->
        resp_frame_o[23:8] == {5'h00, chip_time_setting_i, 8'h80}) else $error("mode answer wrong");
    chk_mode_hold: assert property (periodic_mode_enable_o |=> periodic_mode_enable_o)
        else $error("mode enable dropped");
endmodule
bind dwmd_decoder dwmd_chk chk_u (.clk_sys_i, .rst_n_i, .frame_valid_i, .frame_data_i, .reg_rdata_lo_i,
    .reg_rdata_hi_i, .reg_writable_i, .chip_time_setting_i, .reg_wr_o, .register_byte_address_o, .reg_wdata_o,
    .reg_rd_addr_o, .node_address_register_o, .periodic_mode_enable_o, .periodic_collection_mode_o,
    .resp_valid_o, .resp_frame_o);

// ---- verification/tb.sv ----
// Testbench: commands through the master model, answers compared
`timescale 1ns/1ps
module tb;
    logic        clk_sys_i, rst_n_i, frame_valid_i, reg_writable_i, reg_wr_o, resp_valid_o;
    logic        periodic_mode_enable_o, periodic_collection_mode_o;
    logic [31:0] frame_data_i, resp_frame_o;
    logic [7:0]  reg_rdata_lo_i, reg_rdata_hi_i, register_byte_address_o, reg_wdata_o, reg_rd_addr_o;
    logic [7:0]  node_address_register_o;
    logic [2:0]  chip_time_setting_i;
    logic [7:0]  mem [256];
    int          n_errors, tests_run;
    dwmd_master master_u (.clk_sys_i, .frame_valid_o(frame_valid_i), .frame_data_o(frame_data_i));
    dwmd_decoder dut_u (.clk_sys_i, .rst_n_i, .frame_valid_i, .frame_data_i, .reg_rdata_lo_i, .reg_rdata_hi_i,
        .reg_writable_i, .chip_time_setting_i, .reg_wr_o, .register_byte_address_o, .reg_wdata_o,
        .reg_rd_addr_o, .node_address_register_o, .periodic_mode_enable_o, .periodic_collection_mode_o,
        .resp_valid_o, .resp_frame_o);
    // Register file model; unwritable places ignore the strobe
    assign reg_rdata_lo_i = mem[reg_rd_addr_o];
    assign reg_rdata_hi_i = mem[reg_rd_addr_o + 8'h01];
    always @(posedge clk_sys_i) begin
        if (reg_wr_o === 1'h1 && reg_writable_i) mem[register_byte_address_o] <= reg_wdata_o;
    end
    initial begin
        clk_sys_i = 1'h0;
        forever #25 clk_sys_i = ~clk_sys_i;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One command, answers collected for six cycles (bounded, absence counts)
    task automatic run(input logic [3:0] a, c, input logic [15:0] d, input logic bad, eg,
                       input logic [3:0] ra, input logic [15:0] rd);
        logic        got;
        logic [31:0] fr;
        got = 1'h0;
        fr  = 32'h0;
        master_u.send(a, c, d, bad);
        for (int i = 0; i < 6; i++) begin
            if (resp_valid_o === 1'h1) fr = resp_frame_o;
            if (resp_valid_o === 1'h1) got = 1'h1;
            @(posedge clk_sys_i);
            #1;
        end
        chk(got, eg);
        if (eg) chk(fr, {ra, c, rd, master_u.crc8({ra, c, rd})});
        $display("test %h %h %h done", a, c, d);
    endtask
    task automatic do_reset;
        rst_n_i = 1'h0;
        repeat (5) @(posedge clk_sys_i);
        #1;
        rst_n_i = 1'h1;
        chk({periodic_mode_enable_o, node_address_register_o}, 9'h000);
    endtask
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        rst_n_i = 1'h0;
        reg_writable_i = 1'h1;
        chip_time_setting_i = 3'h5;
        n_errors = 0;
        tests_run = 0;
        for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'hA5;
        do_reset();
        run(4'h0, 4'h8, 16'h1105, 1'h0, 1'h1, 4'h5, {mem[8'h12], 8'h05});
        run(4'h0, 4'h8, 16'h1107, 1'h0, 1'h0, 4'h0, 16'h0000);
        chk(node_address_register_o, 8'h05);
        run(4'h0, 4'h8, 16'h2044, 1'h0, 1'h0, 4'h0, 16'h0000);
        run(4'h3, 4'h8, 16'h2044, 1'h0, 1'h0, 4'h0, 16'h0000);
        run(4'h5, 4'h8, 16'h203C, 1'h1, 1'h0, 4'h0, 16'h0000);
        run(4'h5, 4'h8, 16'h203C, 1'h0, 1'h1, 4'h5, {mem[8'h21], 8'h3C});
        reg_writable_i = 1'h0;
        run(4'h5, 4'h8, 16'h3077, 1'h0, 1'h1, 4'h5, 16'h0000);
        reg_writable_i = 1'h1;
        run(4'h9, 4'hB, 16'h0000, 1'h0, 1'h0, 4'h0, 16'h0000);
        run(4'h5, 4'hB, 16'h0001, 1'h0, 1'h0, 4'h0, 16'h0000);
        chk(periodic_mode_enable_o, 1'h0);
        run(4'h5, 4'hB, 16'h0000, 1'h0, 1'h1, 4'h5, 16'h0580);
        chk({periodic_mode_enable_o, periodic_collection_mode_o}, 2'h3);
        do_reset();
        run(4'h0, 4'h8, 16'h1105, 1'h0, 1'h1, 4'h5, {mem[8'h12], 8'h05});
        run(4'h0, 4'hB, 16'h0000, 1'h0, 1'h0, 4'h0, 16'h0000);
        chk({periodic_mode_enable_o, periodic_collection_mode_o}, 2'h3);
        complete_run();
    end
endmodule
